// *** src/wsn_pkg.sv ***
// Package: register map, field layout, timing and carrier types for the wave/no-load config block
package wsn_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] WSN_CTRL_IDX = 10'h00C; // Sampling enable register
  localparam logic [9:0] WSN_WAVE_IDX = 10'h00D; // Waveform source and rate
  localparam logic [9:0] WSN_NL_IDX = 10'h00E; // No-load thresholds
  localparam logic [9:0] WSN_STAT_IDX = 10'h010; // Read-only state

  // Address layout
  localparam int WSN_AW = 12; // APB address width
  localparam logic [1:0] WSN_ALIGN = 2'h0; // Word alignment bits

  // Reset values
  localparam logic [7:0] WSN_WAVE_RST = 8'h00;
  localparam logic [7:0] WSN_NL_RST = 8'h00;
  localparam logic WSN_EN_RST = 1'h0;

  // Waveform source codes
  localparam logic [2:0] WSN_SRC_CUR = 3'h0;
  localparam logic [2:0] WSN_SRC_VOLT = 3'h1;
  localparam logic [2:0] WSN_SRC_ACT = 3'h2;
  localparam logic [2:0] WSN_SRC_REACT = 3'h3;
  localparam logic [2:0] WSN_SRC_APP = 3'h4;
  localparam logic [2:0] WSN_SRC_IRMS = 3'h5;

  // Sample-clock divisor terminal counts, codes 0..3
  localparam logic [7:0] WSN_DIV32 = 8'h1F;
  localparam logic [7:0] WSN_DIV64 = 8'h3F;
  localparam logic [7:0] WSN_DIV128 = 8'h7F;
  localparam logic [7:0] WSN_DIV256 = 8'hFF;

  // Clock rates: core clock and DSP sample clock
  localparam int WSN_CLK_HZ = 25000000;
  localparam int WSN_DSP_HZ = 819200;
  localparam logic [25:0] WSN_NCO_MOD = 26'(WSN_CLK_HZ);
  localparam logic [25:0] WSN_NCO_INC = 26'(WSN_DSP_HZ);

  // Full scale of a power or current product and thresholds in ppm of it
  localparam logic [63:0] WSN_FULL_SCALE = 64'h00000000007FFFFF;
  localparam logic [63:0] WSN_PPM = 64'd1000000;
  localparam logic [23:0] WSN_TH_300 = 24'((WSN_FULL_SCALE * 64'd300) / WSN_PPM); // 0.030%
  localparam logic [23:0] WSN_TH_150 = 24'((WSN_FULL_SCALE * 64'd150) / WSN_PPM); // 0.015%
  localparam logic [23:0] WSN_TH_75 = 24'((WSN_FULL_SCALE * 64'd75) / WSN_PPM); // 0.0075%
  localparam logic [23:0] WSN_TH_37 = 24'((WSN_FULL_SCALE * 64'd37) / WSN_PPM); // 0.0037%

  // Wave mode register layout
  typedef struct packed {
    logic [2:0] second_wave_source; // Bits 7..5
    logic [2:0] first_wave_source; // Bits 4..2
    logic [1:0] sample_rate_code; // Bits 1..0
  } wsn_wave_t;

  // No-load register layout
  typedef struct packed {
    logic reactive_comp_disable; // Bit 7
    logic rms_current_noload_enable; // Bit 6
    logic [1:0] apparent_noload_level; // Bits 5..4
    logic [1:0] reactive_noload_level; // Bits 3..2
    logic [1:0] active_noload_level; // Bits 1..0
  } wsn_nl_t;

  // Datapath samples offered to the block
  typedef struct packed {
    logic [23:0] current;
    logic [23:0] voltage;
    logic [23:0] active;
    logic [23:0] reactive;
    logic [23:0] apparent;
    logic [31:0] irms;
  } wsn_samples_t;

  // Waveform stream output
  typedef struct packed {
    logic valid;
    logic [31:0] first;
    logic [31:0] second;
  } wsn_wave_out_t;

  // Holds toward energy accumulation and pulse outputs
  typedef struct packed {
    logic irms;
    logic apparent;
    logic reactive;
    logic active;
  } wsn_hold_t;

  // Bus answer phase
  typedef enum logic [1:0] {
    WSN_IDLE = 2'b00,
    WSN_RESP = 2'b01
  } wsn_phase_t;

  // Whole state of the top module
  typedef struct packed {
    wsn_phase_t phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    wsn_wave_t wave;
    wsn_nl_t nl;
    logic wave_en;
    logic [25:0] nco;
    logic [7:0] div_cnt;
    wsn_wave_out_t wout;
    wsn_hold_t hold;
    logic comp_enable;
  } wsn_state_t;

endpackage

// *** src/wsn_noload_cmp.sv ***
// No-load comparator: magnitude against a coded fraction of full scale
`timescale 1ns/1ps
module wsn_noload_cmp #(
  parameter bit HIGH_TABLE = 1'b0 // Apparent table when set, else active/reactive table
) (
  // Setting
  input wire logic [1:0] level,
  // Quantity
  input wire logic [31:0] magnitude,
  // Result
  output logic below
);

  logic [23:0] th; // Chosen threshold

  // Threshold lookup; code zero turns detection off
  always_comb begin
    th = wsn_pkg::WSN_TH_37;
    if (HIGH_TABLE) begin
      case (level)
        2'h1: th = wsn_pkg::WSN_TH_300;
        2'h2: th = wsn_pkg::WSN_TH_150;
        default: th = wsn_pkg::WSN_TH_75;
      endcase
    end else begin
      case (level)
        2'h1: th = wsn_pkg::WSN_TH_150;
        2'h2: th = wsn_pkg::WSN_TH_75;
        default: th = wsn_pkg::WSN_TH_37;
      endcase
    end
    // Zero-extended compare; a wide irms value simply never counts as idle
    below = (level != 2'h0) && (magnitude < {8'h00, th});
  end

endmodule

// *** src/wsn_config_top.sv ***
// Top: APB register bank steering waveform sampling and no-load holds
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
//
// Function
// - Bits 7..5 pick second waveform source
// - Bits 4..2 pick first source, irms low24
// - Rate code divides sample clock 32..256
// - No-load bit 7 disables reactive compensation
// - Bit 6 adds irms no-load via apparent
// - Apparent level: off, 0.030/0.015/0.0075 percent
// - Reactive level: off, 0.015/0.0075/0.0037 percent
// - Active level: off, 0.015/0.0075/0.0037 percent
// - Samples only while sampling enable set
module wsn_config_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wsn_pkg::WSN_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Datapath samples
  input wire wsn_pkg::wsn_samples_t samples,
  // Waveform stream
  output wsn_pkg::wsn_wave_out_t wave_out,
  // Datapath controls
  output wsn_pkg::wsn_hold_t hold,
  output logic reactive_comp_enable
);

  wsn_pkg::wsn_state_t st_reg; // Registered state
  wsn_pkg::wsn_state_t st_next; // Next state
  logic [31:0] mag [4]; // Magnitudes: active, reactive, apparent, irms
  logic [1:0] lvl [4]; // Levels per channel
  logic [3:0] below; // Comparator results
  logic [25:0] nco_sum; // Phase accumulator sum
  logic dsp_tick; // One 819.2 kHz tick
  logic [9:0] idx; // Word index of the access
  logic aligned; // Low address bits clear

  // Absolute value of a signed 24-bit product, widened
  function automatic logic [31:0] abs24(input logic [23:0] v);
    logic [23:0] n;
    n = v[23] ? (~v + 24'h000001) : v;
    return {8'h00, n};
  endfunction

  // Pick one source by code; reserved codes give zero
  function automatic logic [31:0] pick(input logic [2:0] code, input logic low24,
                                       input wsn_pkg::wsn_samples_t s);
    logic [31:0] r;
    r = 32'h00000000;
    case (code)
      wsn_pkg::WSN_SRC_CUR: r = {{8{s.current[23]}}, s.current};
      wsn_pkg::WSN_SRC_VOLT: r = {{8{s.voltage[23]}}, s.voltage};
      wsn_pkg::WSN_SRC_ACT: r = {{8{s.active[23]}}, s.active};
      wsn_pkg::WSN_SRC_REACT: r = {{8{s.reactive[23]}}, s.reactive};
      wsn_pkg::WSN_SRC_APP: r = {{8{s.apparent[23]}}, s.apparent};
      wsn_pkg::WSN_SRC_IRMS: r = low24 ? {8'h00, s.irms[23:0]} : s.irms;
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  // Terminal count of the sample divider for a rate code
  function automatic logic [7:0] rate_term(input logic [1:0] code);
    logic [7:0] t;
    t = wsn_pkg::WSN_DIV256;
    case (code)
      2'h0: t = wsn_pkg::WSN_DIV32;
      2'h1: t = wsn_pkg::WSN_DIV64;
      2'h2: t = wsn_pkg::WSN_DIV128;
      default: t = wsn_pkg::WSN_DIV256;
    endcase
    return t;
  endfunction

  // Read view of the register at an index
  function automatic logic [31:0] read_word(input logic [9:0] i, input wsn_pkg::wsn_state_t s);
    logic [31:0] r;
    r = 32'h00000000;
    if (i == wsn_pkg::WSN_CTRL_IDX) begin
      r = {31'h00000000, s.wave_en};
    end else if (i == wsn_pkg::WSN_WAVE_IDX) begin
      r = {24'h000000, s.wave};
    end else if (i == wsn_pkg::WSN_NL_IDX) begin
      r = {24'h000000, s.nl};
    end else if (i == wsn_pkg::WSN_STAT_IDX) begin
      // Status: compensation, holds, sampling enable
      r = {23'h000000, s.comp_enable, s.hold, 3'h0, s.wave_en};
    end
    return r;
  endfunction

  // Is the index one of ours
  function automatic logic mapped(input logic [9:0] i);
    return (i == wsn_pkg::WSN_CTRL_IDX) || (i == wsn_pkg::WSN_WAVE_IDX) ||
           (i == wsn_pkg::WSN_NL_IDX) || (i == wsn_pkg::WSN_STAT_IDX);
  endfunction

  // Comparator inputs; irms reuses the apparent level when enabled
  always_comb begin
    mag[0] = abs24(samples.active);
    mag[1] = abs24(samples.reactive);
    mag[2] = abs24(samples.apparent);
    mag[3] = samples.irms;
    lvl[0] = st_reg.nl.active_noload_level;
    lvl[1] = st_reg.nl.reactive_noload_level;
    lvl[2] = st_reg.nl.apparent_noload_level;
    // Irms detection gated by its enable bit
    lvl[3] = st_reg.nl.rms_current_noload_enable ? st_reg.nl.apparent_noload_level : 2'h0;
  end

  // One comparator per quantity; apparent and irms use the high table
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cmp
      wsn_noload_cmp #(
        .HIGH_TABLE(g >= 2)
      ) u_cmp (
        .level(lvl[g]),
        .magnitude(mag[g]),
        .below(below[g])
      );
    end
  endgenerate

  // Address split
  assign idx = paddr[wsn_pkg::WSN_AW-1:2];
  assign aligned = (paddr[1:0] == wsn_pkg::WSN_ALIGN);

  // Fractional divider: exact 819.2 kHz on average, jitter of one core cycle
  assign nco_sum = st_reg.nco + wsn_pkg::WSN_NCO_INC;
  assign dsp_tick = (nco_sum >= wsn_pkg::WSN_NCO_MOD);

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    // Bus: answer one cycle after setup
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.phase = wsn_pkg::WSN_IDLE;
    case (st_reg.phase)
      wsn_pkg::WSN_IDLE: begin
        // Setup phase seen: prepare answer
        if (psel && !penable) begin
          st_next.phase = wsn_pkg::WSN_RESP;
          st_next.pready = 1'b1;
          st_next.pslverr = !(aligned && mapped(idx));
          st_next.prdata = (aligned && !pwrite) ? read_word(idx, st_reg) : 32'h00000000;
        end
      end
      wsn_pkg::WSN_RESP: begin
        // Access completes here; writes land only on this edge
        if (psel && penable && pwrite && aligned) begin
          if (idx == wsn_pkg::WSN_CTRL_IDX) begin
            st_next.wave_en = pwdata[0];
          end else if (idx == wsn_pkg::WSN_WAVE_IDX) begin
            st_next.wave = pwdata[7:0];
          end else if (idx == wsn_pkg::WSN_NL_IDX) begin
            st_next.nl = pwdata[7:0];
          end
        end
      end
      default: st_next.phase = wsn_pkg::WSN_IDLE;
    endcase

    // Sample clock accumulator
    st_next.nco = dsp_tick ? (nco_sum - wsn_pkg::WSN_NCO_MOD) : nco_sum;

    // Sample divider and stream; idle and reset to zero while disabled
    st_next.wout.valid = 1'b0;
    if (!st_reg.wave_en) begin
      st_next.div_cnt = 8'h00;
    end else if (dsp_tick) begin
      if (st_reg.div_cnt >= rate_term(st_reg.wave.sample_rate_code)) begin
        // Rate change takes effect at once: each tick compares the count with the current rate code's terminal
        st_next.div_cnt = 8'h00;
        st_next.wout.valid = 1'b1;
        st_next.wout.first = pick(st_reg.wave.first_wave_source, 1'b1, samples);
        st_next.wout.second = pick(st_reg.wave.second_wave_source, 1'b0, samples);
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 8'h01;
      end
    end

    // Datapath controls, one cycle behind the inputs
    st_next.hold = below;
    st_next.comp_enable = !st_reg.nl.reactive_comp_disable;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{phase: wsn_pkg::WSN_IDLE, pready: 1'b0, pslverr: 1'b0,
                  prdata: 32'h00000000, wave: wsn_pkg::WSN_WAVE_RST, nl: wsn_pkg::WSN_NL_RST,
                  wave_en: wsn_pkg::WSN_EN_RST, nco: 26'h0000000, div_cnt: 8'h00,
                  wout: '0, hold: '0, comp_enable: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign prdata = st_reg.prdata;
  assign wave_out = st_reg.wout;
  assign hold = st_reg.hold;
  assign reactive_comp_enable = st_reg.comp_enable;

endmodule

// *** verification/wsn_config_properties.sv ***
// Checker: port-level relations of the wave and no-load config bank
`timescale 1ns/1ps
module wsn_config_properties (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wsn_pkg::WSN_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Datapath side
  input wire wsn_pkg::wsn_samples_t samples,
  input wire wsn_pkg::wsn_wave_out_t wave_out,
  input wire wsn_pkg::wsn_hold_t hold,
  input wire logic reactive_comp_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadows rebuilt from accepted bus writes
  logic wr;
  logic [7:0] nl_sh;
  logic [7:0] wv_sh;
  logic en_sh;
  logic seen;
  logic [15:0] gap;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  // Gap count only trusted once no write disturbed the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nl_sh <= 8'h00;
      wv_sh <= 8'h00;
      en_sh <= 1'b0;
      seen <= 1'b0;
      gap <= 16'h0000;
    end else begin
      if (wr && paddr == 12'h038) nl_sh <= pwdata[7:0];
      if (wr && paddr == 12'h034) wv_sh <= pwdata[7:0];
      if (wr && paddr == 12'h030) en_sh <= pwdata[0];
      seen <= wr ? 1'b0 : (seen | wave_out.valid);
      gap <= wave_out.valid ? 16'h0000 : gap + 16'h0001;
    end
  end
  // Threshold of a level; zero means nothing counts as below
  function automatic logic [31:0] th(input logic hi, input logic [1:0] l);
    case (l)
      2'h1: th = hi ? 32'(wsn_pkg::WSN_TH_300) : 32'(wsn_pkg::WSN_TH_150);
      2'h2: th = hi ? 32'(wsn_pkg::WSN_TH_150) : 32'(wsn_pkg::WSN_TH_75);
      2'h3: th = hi ? 32'(wsn_pkg::WSN_TH_75) : 32'(wsn_pkg::WSN_TH_37);
      default: th = 32'h0;
    endcase
  endfunction
  // Magnitude kept at 24 bits before widening, so negation cannot smear upper bits
  function automatic logic [31:0] ab(input logic [23:0] v);
    ab = {8'h00, v[23] ? 24'(~v + 24'h000001) : v};
  endfunction
  // Expected stream word for a source code
  function automatic logic [31:0] pk(input logic [2:0] c, input logic lo,
                                     input wsn_pkg::wsn_samples_t s);
    if (c > 3'h5) pk = 32'h0;
    else if (c == 3'h5) pk = lo ? {8'h00, s.irms[23:0]} : s.irms;
    else pk = 32'(signed'(s[151 - 24 * c -: 24]));
  endfunction
  comp_follow_a: assert property (reactive_comp_enable == !$past(nl_sh[7]))
    else $error("compensation enable does not follow its bit");
  hold_active_a: assert property (
    hold.active == $past(ab(samples.active) < th(1'b0, nl_sh[1:0])))
    else $error("active hold wrong");
  hold_reactive_a: assert property (
    hold.reactive == $past(ab(samples.reactive) < th(1'b0, nl_sh[3:2])))
    else $error("reactive hold wrong");
  hold_apparent_a: assert property (
    hold.apparent == $past(ab(samples.apparent) < th(1'b1, nl_sh[5:4])))
    else $error("apparent hold wrong");
  hold_irms_a: assert property (
    hold.irms == $past(nl_sh[6] && samples.irms < th(1'b1, nl_sh[5:4])))
    else $error("rms current hold wrong");
  stream_off_a: assert property (!en_sh && !$past(en_sh) |-> !wave_out.valid)
    else $error("sample while sampling disabled");
  second_src_a: assert property (
    wave_out.valid |-> wave_out.second == $past(pk(wv_sh[7:5], 1'b0, samples)))
    else $error("second stream word wrong");
  first_src_a: assert property (
    wave_out.valid |-> wave_out.first == $past(pk(wv_sh[4:2], 1'b1, samples)))
    else $error("first stream word wrong");
  rate_gap_a: assert property (wave_out.valid && seen |->
    gap >= (16'h03C0 << wv_sh[1:0]) - 16'h0001 && gap <= (16'h03E0 << wv_sh[1:0]) - 16'h0001)
    else $error("stream spacing wrong");
  cover property (wave_out.valid && seen);
  cover property (hold.irms);
  cover property (pready && pslverr);
endmodule

bind wsn_config_top wsn_config_properties u_wsn_config_properties (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .samples, .wave_out, .hold,
  .reactive_comp_enable);

// *** verification/wsn_config_top_tb.sv ***
// Testbench: registers, no-load holds and waveform stream of the config bank
`timescale 1ns/1ps
module wsn_config_top_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  wsn_pkg::wsn_samples_t smp;
  wsn_pkg::wsn_wave_out_t wout;
  wsn_pkg::wsn_hold_t hld;
  logic rce;
  logic [31:0] rdat;
  logic rerr;
  int fails = 0;
  int samples_checked = 0;
  wsn_config_top u_wsn_config_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .samples(smp), .wave_out(wout), .hold(hld),
    .reactive_comp_enable(rce));
  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles until the next stream pulse, capped
  task automatic wv(input int lim, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (wout.valid !== 1'b1 && k < lim);
  endtask
  function automatic logic [31:0] pick(input logic [2:0] c, input logic lo);
    if (c > 3'h5) pick = 32'h0;
    else if (c == 3'h5) pick = lo ? {8'h00, smp.irms[23:0]} : smp.irms;
    else pick = 32'(signed'(smp[151 - 24 * c -: 24]));
  endfunction
  task automatic t_regs;
    apb(1'b0, 12'h034, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h038, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, 12'h034, 32'h1234_56B5);
    apb(1'b0, 12'h034, 32'h0);
    chk(rdat, 32'h0000_00B5);
    apb(1'b1, 12'h036, 32'h0);
    chk(32'(rerr), 32'h1);
    apb(1'b0, 12'h034, 32'h0);
    chk(rdat, 32'h0000_00B5);
    apb(1'b0, 12'h044, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h8000_0000);
    $display("test regs done");
  endtask
  // Status readback, then a mid-run reset must clear the control, wave and no-load registers
  task automatic t_reset;
    apb(1'b1, 12'h038, 32'hC5);
    apb(1'b1, 12'h030, 32'h1);
    apb(1'b0, 12'h040, 32'h0);
    chk(rdat, 32'h0000_0031);
    chk(32'(rce), 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h034, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h038, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk(rdat, 32'h0);
    chk(32'(rce), 32'h1);
    $display("test reset done");
  endtask
  task automatic t_comp;
    chk(32'(rce), 32'h1);
    apb(1'b1, 12'h038, 32'h80);
    repeat (3) @(posedge pclk);
    chk(32'(rce), 32'h0);
    apb(1'b1, 12'h038, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(rce), 32'h1);
    $display("test compensation done");
  endtask
  // Just below and exactly at each threshold; active driven negative
  task automatic t_noload;
    logic [63:0] ph[4] = '{64'h0, 64'h12C, 64'h96, 64'h4B};
    logic [63:0] pl[4] = '{64'h0, 64'h96, 64'h4B, 64'h25};
    logic [31:0] tl;
    logic [31:0] ta;
    for (int l = 0; l < 4; l++) begin
      tl = 32'((wsn_pkg::WSN_FULL_SCALE * pl[l]) / 64'hF4240);
      ta = 32'((wsn_pkg::WSN_FULL_SCALE * ph[l]) / 64'hF4240);
      apb(1'b1, 12'h038, {24'h0, 2'b01, 2'(l), 2'(l), 2'(l)});
      for (int d = 0; d < 2; d++) begin
        smp.active <= 24'(-(tl - 1 + d));
        smp.reactive <= 24'(tl - 1 + d);
        smp.apparent <= 24'(ta - 1 + d);
        smp.irms <= ta - 1 + d;
        repeat (3) @(posedge pclk);
        chk(32'(hld), (l != 0 && d == 0) ? 32'hF : 32'h0);
      end
    end
    apb(1'b1, 12'h038, 32'h30);
    smp.irms <= 32'h0;
    smp.apparent <= 24'h0;
    repeat (3) @(posedge pclk);
    chk(32'(hld), 32'h4);
    apb(1'b1, 12'h038, 32'h0);
    $display("test no-load done");
  endtask
  // First-side codes 5 down to 2, second-side codes 5, 1, 0 and 6, every rate code
  task automatic t_wave;
    int k;
    logic [1:0] r2;
    // Second-side codes: full irms, voltage, current, reserved
    logic [2:0] s2[4] = '{3'h5, 3'h1, 3'h0, 3'h6};
    smp <= '{24'h800123, 24'h123456, 24'h7ABCDE, 24'hF00001, 24'h0C0FFE, 32'hABCDEF12};
    wv(1500, k);
    chk(k, 1500);
    for (int r = 0; r < 4; r++) begin
      r2 = 2'(r);
      apb(1'b1, 12'h034, {24'h0, s2[r], 3'(5 - r), r2});
      apb(1'b1, 12'h030, 32'h1);
      wv(9000, k);
      wv(9000, k);
      chk(32'(k >= (32'h3C0 << r) && k <= (32'h3E0 << r)), 32'h1);
      chk(wout.second, pick(s2[r], 1'b0));
      chk(wout.first, pick(3'(5 - r), 1'b1));
      apb(1'b1, 12'h030, 32'h0);
    end
    $display("test stream done");
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    smp = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_reset;
    t_comp;
    t_noload;
    t_wave;
    stop_test;
  end
  // Watchdog well past the longest expected run
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    stop_test;
  end
endmodule
